/* logic/bwf_consts.svh */
`ifndef BWF_CONSTS_SVH
`define BWF_CONSTS_SVH

// ==========================================================
// register byte offsets
`define BWF_OFS_WIN_CTL     8'h38
`define BWF_OFS_Q2_MAP      8'h3C
`define BWF_OFS_Q3_MAP      8'h40
`define BWF_OFS_STATUS      8'h44

// ==========================================================
// field positions
`define BWF_CFG_SEL_MSB     1
`define BWF_BIT_SPLIT       2
`define BWF_BIT_IGNORE      3
`define BWF_SIZE_LSB        16
`define BWF_SIZE_MSB        31
`define BWF_MAP_MSB         15

// ==========================================================
// reset values
`define BWF_SIZE_RST        16'hFFFF
`define BWF_MAP_RST         16'h0000
`define BWF_CFG_SEL_RST     2'h0
`define BWF_SPLIT_RST       1'h0
`define BWF_IGNORE_RST      1'h1

// ==========================================================
// endpoint codes
`define BWF_EP_CODE_MAX     3'h3
`define BWF_DIR_IN          1'h1

`endif

/* logic/bwf_pkg.sv */
package bwf_pkg;

  // ==========================================================
  // host memory request and its completion
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } bwf_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        retry;
    logic [1:0]  ep;
    logic        dirIn;
    logic [31:0] data;
  } bwf_cpl_t;

  // ==========================================================
  // register slave states, gray along idle -> answer
  typedef enum logic [1:0] {
    BWF_IDLE   = 2'h0,
    BWF_ANSWER = 2'h1
  } bwf_slave_t;

endpackage

/* logic/bwf_window_decode.sv */
`timescale 1ns/1ps

module bwf_window_decode (
  // window setup
  input  wire logic [31:0] base,
  input  wire logic [15:0] size,
  // access address
  input  wire logic [31:0] addr,
  // result
  output logic             hit,
  output logic [1:0]       quadrant
);
  import bwf_pkg::*;

  logic [31:0] mask;
  logic [4:0]  steps;
  logic [31:0] shifted;

  // range is 64 KB doubled once per cleared bit from bit 16 upward
  always_comb begin
    mask  = {size, 16'h0000};
    steps = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (size[i]) begin
        steps = i[4:0];
      end
    end
    shifted  = addr >> steps;
    quadrant = shifted[15:14];
    // zero size means a 4 GB range, which disables the window
    hit = (size != 16'h0000) && ((addr & mask) == (base & mask));
  end

endmodule

/* logic/bwf_quadrant_map.sv */
`timescale 1ns/1ps
`include "bwf_consts.svh"

module bwf_quadrant_map (
  // four 4-bit endpoint/direction fields
  input  wire logic [15:0] fields,
  input  wire logic [1:0]  quadrant,
  // selected endpoint
  output logic             valid,
  output logic [1:0]       ep,
  output logic             dirIn
);
  import bwf_pkg::*;

  logic [3:0] field;

  always_comb begin
    field = fields[{quadrant, 2'h0} +: 4];
    // codes above endpoint 3 are reserved and decode to nothing
    valid = field[3:1] <= `BWF_EP_CODE_MAX;
    ep    = field[2:1];
    dirIn = field[0] == `BWF_DIR_IN;
  end

endmodule

/* logic/bwf_decoder.sv */
`timescale 1ns/1ps
`include "bwf_consts.svh"

// Notes on behaviour
// - Legacy mode with split select 0 gives endpoints 0..3 one quadrant each of the second window in order.
// - Legacy split mode sends lower-half writes to endpoint 0 and lower-half reads to endpoint 1.
// - Legacy split mode sends upper-half writes to endpoint 2.
// - With ignore-availability 0 a read from an empty FIFO or a write to a full FIFO ends in retry; the bit is 3, reset 1.
// - With ignore-availability 1 such accesses complete normally, read data undefined, write data dropped.
// - The second window size field in bits 31:16 masks address bits 31:16, the range doubling from 64 KB per cleared low bit, reset FFFFh meaning 64 KB.
// - A size of zero means 4 GB and disables the second window.
// - In enhanced mode the legacy split bit and size field are reserved; the quadrant map register takes over.
// - Both quadrant map registers work only in enhanced mode and are reserved in legacy mode.
// - In enhanced mode each second-window quadrant maps through a 4-bit field at 3:0, 7:4, 11:8, 15:12, reset 0.
// - In each field bit 0 is the direction and bits 3:1 the endpoint number.
// - Endpoint codes 000b to 011b select endpoints 0 to 3; other codes are reserved.
// - In enhanced mode the third window quadrants map through the same kind of fields.
// - The third window size field works like the second, zero disabling the window.
module bwf_decoder (
  // clock and control
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  // adapter mode strap pin
  input  wire logic                enhancedModePin,
  // window bases from configuration space
  input  wire logic [31:0]         secondWindowBase,
  input  wire logic [31:0]         thirdWindowBase,
  // host memory request
  input  wire logic                reqValid,
  input  wire bwf_pkg::bwf_req_t   req,
  output bwf_pkg::bwf_cpl_t        cpl,
  // endpoint FIFOs
  input  wire logic [3:0]          fifoEmpty,
  input  wire logic [3:0]          fifoFull,
  input  wire logic [3:0][31:0]    fifoHead,
  output logic [3:0]               fifoWrEn,
  output logic [3:0]               fifoRdEn,
  output logic [31:0]              fifoWrData,
  output logic                     fifoDirIn,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest
);
  import bwf_pkg::*;

  // ==========================================================
  // mode strap synchroniser
  logic enhSync1;
  logic enhanced;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enhSync1 <= 1'b0;
      enhanced <= 1'b0;
    end else if (clkEn) begin
      enhSync1 <= enhancedModePin;
      enhanced <= enhSync1;
    end
  end

  // ==========================================================
  // registers
  logic [1:0]  cfgSelect;
  logic        splitSelect;
  logic        ignoreAvail;
  logic [15:0] legacySize;
  logic [15:0] secondMap;
  logic [15:0] secondSize;
  logic [15:0] thirdMap;
  logic [15:0] thirdSize;
  logic [31:0] byteMask;
  logic        wrStrobe;
  bwf_slave_t  slaveState;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byteMask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // the write lands in the answer cycle, the one edge where waitrequest is low
  assign wrStrobe = (slaveState == BWF_ANSWER) && avs_write;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfgSelect   <= `BWF_CFG_SEL_RST;
      splitSelect <= `BWF_SPLIT_RST;
      ignoreAvail <= `BWF_IGNORE_RST;
      legacySize  <= `BWF_SIZE_RST;
    end else if (clkEn && wrStrobe && avs_address == `BWF_OFS_WIN_CTL) begin
      if (avs_byteenable[0]) begin
        cfgSelect   <= avs_writedata[`BWF_CFG_SEL_MSB:0];
        ignoreAvail <= avs_writedata[`BWF_BIT_IGNORE];
        if (!enhanced) begin
          splitSelect <= avs_writedata[`BWF_BIT_SPLIT];
        end
      end
      if (!enhanced) begin
        legacySize <= (legacySize & ~byteMask[31:16]) | (avs_writedata[31:16] & byteMask[31:16]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      secondMap  <= `BWF_MAP_RST;
      secondSize <= `BWF_SIZE_RST;
      thirdMap   <= `BWF_MAP_RST;
      thirdSize  <= `BWF_SIZE_RST;
    end else if (clkEn && wrStrobe && enhanced) begin
      if (avs_address == `BWF_OFS_Q2_MAP) begin
        secondMap  <= (secondMap & ~byteMask[15:0]) | (avs_writedata[15:0] & byteMask[15:0]);
        secondSize <= (secondSize & ~byteMask[31:16]) | (avs_writedata[31:16] & byteMask[31:16]);
      end
      if (avs_address == `BWF_OFS_Q3_MAP) begin
        thirdMap  <= (thirdMap & ~byteMask[15:0]) | (avs_writedata[15:0] & byteMask[15:0]);
        thirdSize <= (thirdSize & ~byteMask[31:16]) | (avs_writedata[31:16] & byteMask[31:16]);
      end
    end
  end

  // ==========================================================
  // window decode
  logic [15:0] activeSecondSize;
  logic        secondHit;
  logic        thirdHit;
  logic [1:0]  secondQuad;
  logic [1:0]  thirdQuad;

  assign activeSecondSize = enhanced ? secondSize : legacySize;

  bwf_window_decode u_secondWindow (
    .base     (secondWindowBase),
    .size     (activeSecondSize),
    .addr     (req.addr),
    .hit      (secondHit),
    .quadrant (secondQuad)
  );

  bwf_window_decode u_thirdWindow (
    .base     (thirdWindowBase),
    .size     (thirdSize),
    .addr     (req.addr),
    .hit      (thirdHit),
    .quadrant (thirdQuad)
  );

  // ==========================================================
  // quadrant maps
  logic       secondMapValid;
  logic [1:0] secondMapEp;
  logic       secondMapDir;
  logic       thirdMapValid;
  logic [1:0] thirdMapEp;
  logic       thirdMapDir;

  bwf_quadrant_map u_secondMap (
    .fields   (secondMap),
    .quadrant (secondQuad),
    .valid    (secondMapValid),
    .ep       (secondMapEp),
    .dirIn    (secondMapDir)
  );

  bwf_quadrant_map u_thirdMap (
    .fields   (thirdMap),
    .quadrant (thirdQuad),
    .valid    (thirdMapValid),
    .ep       (thirdMapEp),
    .dirIn    (thirdMapDir)
  );

  // ==========================================================
  // steering and availability
  logic       next_hit;
  logic [1:0] next_ep;
  logic       next_dirIn;
  logic       busy;
  logic       next_retry;

  always_comb begin
    next_hit   = 1'b0;
    next_ep    = 2'h0;
    next_dirIn = ~req.write;
    if (!enhanced) begin
      next_hit = secondHit;
      if (splitSelect) begin
        // lower half: write ep0, read ep1; upper half: write ep2, read ep3
        next_ep = {secondQuad[1], ~req.write};
      end else begin
        next_ep = secondQuad;
      end
    end else if (secondHit) begin
      // second window wins if a host overlaps the two
      next_hit   = secondMapValid;
      next_ep    = secondMapEp;
      next_dirIn = secondMapDir;
    end else if (thirdHit) begin
      next_hit   = thirdMapValid;
      next_ep    = thirdMapEp;
      next_dirIn = thirdMapDir;
    end
    busy       = req.write ? fifoFull[next_ep] : fifoEmpty[next_ep];
    next_retry = next_hit && busy && !ignoreAvail;
  end

  // ==========================================================
  // completion and FIFO strobes, one cycle after the request
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cpl        <= '0;
      fifoWrEn   <= 4'h0;
      fifoRdEn   <= 4'h0;
      fifoWrData <= 32'h0000_0000;
      fifoDirIn  <= 1'b0;
    end else if (clkEn) begin
      cpl.valid <= reqValid;
      cpl.hit   <= reqValid && next_hit;
      cpl.retry <= reqValid && next_retry;
      cpl.ep    <= next_ep;
      cpl.dirIn <= next_dirIn;
      fifoDirIn <= next_dirIn;
      fifoWrEn  <= 4'h0;
      fifoRdEn  <= 4'h0;
      cpl.data  <= 32'h0000_0000;
      // a busy FIFO is never strobed, so ignored writes are dropped
      if (reqValid && next_hit && !busy) begin
        if (req.write) begin
          fifoWrEn[next_ep] <= 1'b1;
          fifoWrData        <= req.data;
        end else begin
          fifoRdEn[next_ep] <= 1'b1;
          cpl.data          <= fifoHead[next_ep];
        end
      end
    end
  end

  // ==========================================================
  // last access status, readable by software
  logic       lastHit;
  logic       lastRetry;
  logic [1:0] lastEp;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lastHit   <= 1'b0;
      lastRetry <= 1'b0;
      lastEp    <= 2'h0;
    end else if (clkEn && reqValid) begin
      lastHit   <= next_hit;
      lastRetry <= next_retry;
      lastEp    <= next_ep;
    end
  end

  // ==========================================================
  // Avalon slave: every access answers in the cycle after it is seen
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      `BWF_OFS_WIN_CTL: begin
        next_readdata[`BWF_CFG_SEL_MSB:0] = cfgSelect;
        next_readdata[`BWF_BIT_IGNORE]    = ignoreAvail;
        if (!enhanced) begin
          next_readdata[`BWF_BIT_SPLIT]                   = splitSelect;
          next_readdata[`BWF_SIZE_MSB:`BWF_SIZE_LSB]      = legacySize;
        end
      end
      `BWF_OFS_Q2_MAP: begin
        if (enhanced) begin
          next_readdata = {secondSize, secondMap};
        end
      end
      `BWF_OFS_Q3_MAP: begin
        if (enhanced) begin
          next_readdata = {thirdSize, thirdMap};
        end
      end
      `BWF_OFS_STATUS: begin
        next_readdata[4:0] = {enhanced, lastEp, lastRetry, lastHit};
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slaveState      <= BWF_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (clkEn) begin
      unique case (slaveState)
        BWF_IDLE: begin
          if (avs_read || avs_write) begin
            slaveState      <= BWF_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= next_readdata;
          end
        end
        BWF_ANSWER: begin
          slaveState      <= BWF_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* bench/bwf_host_model.sv */
`timescale 1ns/1ps

module bwf_host_model import bwf_pkg::*; #(
  parameter logic [31:0] SECOND_BASE = 32'h10000000,
  parameter logic [31:0] THIRD_BASE  = 32'h20000000
) (
  // clock
  input  wire logic         mclk,
  // host side
  output logic              reqValid,
  output bwf_pkg::bwf_req_t req,
  output logic [31:0]       secondWindowBase,
  output logic [31:0]       thirdWindowBase
);
  // bases sit on a 256 MB boundary so every tested range divides them
  assign secondWindowBase = SECOND_BASE;
  assign thirdWindowBase  = THIRD_BASE;

  initial begin
    reqValid = 1'b0;
    req      = '0;
  end

  // one request per call; released fields are inverted so stale values never look valid
  task automatic issue(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reqValid <= 1'b1;
    req      <= '{w, a, d};
    @(posedge mclk);
    reqValid <= 1'b0;
    req      <= '{~w, ~a, ~d};
  endtask
endmodule

/* bench/bwf_decoder_sva.sv */
`timescale 1ns/1ps

module bwf_decoder_sva import bwf_pkg::*; (
  // clock and control
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              clkEn,
  // host side
  input wire logic              reqValid,
  input wire bwf_pkg::bwf_req_t req,
  input wire bwf_pkg::bwf_cpl_t cpl,
  // fifo side
  input wire logic [3:0]        fifoWrEn,
  input wire logic [3:0]        fifoRdEn,
  input wire logic [31:0]       fifoWrData,
  // register bus
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence takeReq;
    reqValid && clkEn;
  endsequence
  sequence takeBus;
    $rose(avs_read || avs_write) && clkEn;
  endsequence

  cpl_answer_a: assert property (takeReq |=> cpl.valid) else $error("request without completion");
  cpl_cause_a: assert property (cpl.valid |-> $past(reqValid)) else $error("completion without request");
  bus_answer_a: assert property (takeBus |=> !avs_waitrequest) else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  miss_quiet_a: assert property (cpl.valid && !cpl.hit |-> fifoWrEn == 4'h0 && fifoRdEn == 4'h0 && !cpl.retry)
    else $error("miss touched a fifo");
  retry_quiet_a: assert property (cpl.valid && cpl.retry |-> fifoWrEn == 4'h0 && fifoRdEn == 4'h0)
    else $error("retry touched a fifo");
  wr_onehot_a: assert property (fifoWrEn != 4'h0 |-> fifoWrEn == (4'h1 << cpl.ep) && cpl.hit && $past(req.write))
    else $error("write strobe wrong");
  wr_data_a: assert property (fifoWrEn != 4'h0 |-> fifoWrData == $past(req.data))
    else $error("write data wrong");
  rd_onehot_a: assert property (fifoRdEn != 4'h0 |-> fifoRdEn == (4'h1 << cpl.ep) && !$past(req.write))
    else $error("read strobe wrong");
endmodule

bind bwf_decoder bwf_decoder_sva u_sva (
  .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .reqValid(reqValid), .req(req), .cpl(cpl),
  .fifoWrEn(fifoWrEn), .fifoRdEn(fifoRdEn), .fifoWrData(fifoWrData),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest)
);

/* bench/test_bar_window_fifo_decoder.sv */
`timescale 1ns/1ps

module test_bar_window_fifo_decoder;
  import bwf_pkg::*;
  localparam logic [31:0] B2 = 32'h10000000;
  localparam logic [31:0] B3 = 32'h20000000;
  // expected outcome: {strobe, valid, hit, retry}
  localparam logic [3:0] OK = 4'hE, IGN = 4'h6, RTY = 4'h7, MISS = 4'h4;

  logic mclk, reset_n, clkEn, enhancedModePin, reqValid, avs_read, avs_write, avs_waitrequest, fifoDirIn;
  logic [31:0] b2, b3, fifoWrData, avs_writedata, avs_readdata, q;
  logic [3:0] fifoEmpty, fifoFull, fifoWrEn, fifoRdEn, avs_byteenable;
  logic [3:0][31:0] fifoHead;
  logic [7:0] avs_address;
  bwf_req_t req;
  bwf_cpl_t cpl;
  int nMismatch = 0;
  int totalChecks = 0;

  always #5 mclk = ~mclk;

  bwf_host_model #(.SECOND_BASE(B2), .THIRD_BASE(B3)) host (.mclk(mclk), .reqValid(reqValid), .req(req),
    .secondWindowBase(b2), .thirdWindowBase(b3));

  bwf_decoder DUT (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .enhancedModePin(enhancedModePin),
    .secondWindowBase(b2), .thirdWindowBase(b3), .reqValid(reqValid), .req(req), .cpl(cpl),
    .fifoEmpty(fifoEmpty), .fifoFull(fifoFull), .fifoHead(fifoHead), .fifoWrEn(fifoWrEn),
    .fifoRdEn(fifoRdEn), .fifoWrData(fifoWrData), .fifoDirIn(fifoDirIn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low; the bound only guards a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "bus hang");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, "register read");
  endtask

  task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] exp, input logic [1:0] ep);
    logic [3:0] strobe;
    host.issue(w, a, a ^ 32'hC0DE0000);
    // the completion launched one edge after the request still stands at this edge
    @(posedge mclk);
    strobe = w ? fifoWrEn : fifoRdEn;
    chk({29'h0, cpl.valid, cpl.hit, cpl.retry}, {29'h0, exp[2:0]}, "completion");
    chk({28'h0, strobe}, exp[3] ? 32'h1 << ep : 32'h0, "strobe");
    if (exp[3]) chk({30'h0, cpl.ep}, {30'h0, ep}, "endpoint");
    if (exp[3] && w) chk(fifoWrData, a ^ 32'hC0DE0000, "write data");
    if (!w && exp != RTY) chk(cpl.data, exp[3] ? fifoHead[ep] : 32'h0, "read data");
    if (!enhancedModePin) chk({30'h0, cpl.dirIn, fifoDirIn}, {30'h0, !w, !w}, "legacy direction");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(8'h38, 32'hFFFF0008);
    rd(8'h3C, 32'h0);
    bus(1'b1, 8'h3C, 32'h00001234, q);
    rd(8'h3C, 32'h0);
    rd(8'h10, 32'h0);
    $display("test regs done");
  endtask

  // a request seen while the clock enable is low must leave no trace
  task automatic t_freeze;
    clkEn <= 1'b0;
    host.issue(1'b1, B2, 32'h0);
    @(posedge mclk);
    chk({28'h0, fifoWrEn}, 32'h0, "frozen strobe");
    chk({31'h0, cpl.valid}, 32'h0, "frozen completion");
    clkEn <= 1'b1;
    $display("test freeze done");
  endtask

  task automatic t_quad;
    for (int i = 0; i < 4; i++) acc(1'b1, B2 + i * 32'h4000, OK, i[1:0]);
    acc(1'b0, B2 + 32'hC000, OK, 2'h3);
    $display("test quadrants done");
  endtask

  task automatic t_split;
    bus(1'b1, 8'h38, 32'hFFFF000C, q);
    acc(1'b1, B2, OK, 2'h0);
    acc(1'b0, B2 + 32'h4000, OK, 2'h1);
    acc(1'b1, B2 + 32'h8000, OK, 2'h2);
    acc(1'b0, B2 + 32'hC000, OK, 2'h3);
    $display("test split done");
  endtask

  task automatic t_busy;
    fifoFull <= 4'h4;
    acc(1'b1, B2 + 32'h8000, IGN, 2'h2);
    bus(1'b1, 8'h38, 32'hFFFF0004, q);
    acc(1'b1, B2 + 32'h8000, RTY, 2'h2);
    fifoEmpty <= 4'h8;
    acc(1'b0, B2 + 32'hC000, RTY, 2'h3);
    rd(8'h44, 32'h0000000F);
    acc(1'b0, B2, OK, 2'h1);
    fifoFull  <= 4'h0;
    fifoEmpty <= 4'h0;
    $display("test busy done");
  endtask

  task automatic t_size;
    bus(1'b1, 8'h38, 32'hFFFE0008, q);
    acc(1'b1, B2 + 32'h8000, OK, 2'h1);
    acc(1'b1, B2 + 32'h10000, OK, 2'h2);
    bus(1'b1, 8'h38, 32'h00000008, q);
    acc(1'b1, B2, MISS, 2'h0);
    bus(1'b1, 8'h38, 32'hFFFF0008, q);
    $display("test size done");
  endtask

  task automatic t_enh;
    enhancedModePin <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h38, 32'h00000008);
    rd(8'h40, 32'hFFFF0000);
    bus(1'b1, 8'h3C, 32'hFFFF8347, q);
    rd(8'h3C, 32'hFFFF8347);
    acc(1'b0, B2, OK, 2'h3);
    chk({30'h0, cpl.dirIn, fifoDirIn}, 32'h3, "direction in");
    acc(1'b1, B2 + 32'h4000, OK, 2'h2);
    chk({30'h0, cpl.dirIn, fifoDirIn}, 32'h0, "direction out");
    acc(1'b1, B2 + 32'h8000, OK, 2'h1);
    acc(1'b1, B2 + 32'hC000, MISS, 2'h0);
    acc(1'b1, B3 + 32'hC000, OK, 2'h0);
    bus(1'b1, 8'h40, 32'h00000006, q);
    acc(1'b1, B3, MISS, 2'h0);
    $display("test enhanced done");
  endtask

  // ==========================================================
  // run control
  task automatic stop_test;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    nMismatch++;
    stop_test;
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    enhancedModePin = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    fifoEmpty = 4'h0;
    fifoFull = 4'h0;
    fifoHead = {32'hD3D3D3D3, 32'hC2C2C2C2, 32'hB1B1B1B1, 32'hA0A0A0A0};
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    t_freeze;
    t_quad;
    t_split;
    t_busy;
    t_size;
    t_enh;
    stop_test;
  end
endmodule
